// ### dq_channel_sel.sv
// ============================================================
// Output source multiplexer for one channel (combinational).
// Assumes inputs are already the consistent per-cycle image.
`timescale 1ns/1ps
module dq_channel_sel (
	dq_sel_if.sel s // Channel selector signals
);
	// Module control when selected, or always in DC motor mode
	always_comb begin
		s.out_a = 1'b0;
		s.out_b = 1'b0;
		s.fault_b_req = 1'b0;
		if (s.dc_motor) begin
			s.out_a = s.gen_a;
			s.out_b = s.gen_b;
		end else if (s.source_sel) begin
			s.out_a = s.active & s.gen_a;
			s.out_b = 1'b0;
		end else begin
			s.out_a = s.level_a;
			s.out_b = s.level_b & ~s.level_a;
			s.fault_b_req = s.level_a & s.level_b;
		end
	end
endmodule

// ### dq_output_direct_control.sv
// ============================================================
// Two-channel output source selector with background sequence.
// Assumes the bus front end writes control bytes with i_wr and
// marks the cycle start instant with a one-cycle i_cycle_start.
`timescale 1ns/1ps
// Operation
// - In isochronous mode a software-only start begins at the cycle start instant.
// - In isochronous mode all control bytes are taken over as one set per cycle.
// - In isochronous mode all feedback bytes are presented as one snapshot per cycle.
// - In isochronous PWM mode the modulation period is aligned to the bus cycle.
// - The sequence keeps running while direct control is selected.
// - Both manual levels set drives only A high, B low, and sets the B fault flag.
// - The B fault flag stays set until error acknowledge clears it.
// - Source select set with the sequence active reconnects the generator.
// - Under module control B is low except in DC motor mode.
// - DC motor mode ignores source select and manual levels.
// - A rising software enable starts the sequence, zero cancels it.
// - Manual level A at bit 3 drives output A under direct control.
// - Manual level B at bit 4 drives B only while A is clear.
module dq_output_direct_control
	import dq_pkg::*;
(
	input wire logic i_clk, // 50 MHz clock
	input wire logic i_rst_n, // Async reset, active low
	input wire logic i_wr, // Control byte write strobe
	input wire logic [7:0] i_addr, // Control byte offset
	input wire logic [7:0] i_wdata, // Control byte data
	input wire logic i_isochronous, // Isochronous mode select
	input wire logic i_cycle_start, // Cycle start instant pulse
	input wire logic i_update, // Control image update pulse
	input wire logic [1:0] i_hw_enable_pin, // Hardware enable pins (async)
	input wire logic [1:0] i_hw_enable_use, // Qualify start by hardware enable
	input wire logic [1:0] i_dc_motor, // DC motor mode per channel
	input wire logic [1:0] i_pwm_mode, // PWM mode per channel
	input wire logic [1:0] i_gen_a, // Generator output A per channel
	input wire logic [1:0] i_gen_b, // Generator output B per channel
	input wire logic [1:0] i_seq_done, // Generator finished sequence
	output logic [1:0] o_pulse_output_a, // Output A per channel
	output logic [1:0] o_pulse_output_b, // Output B per channel
	output logic [1:0] o_seq_run, // Sequence running to generator
	output logic [1:0] o_period_sync, // PWM period restart to generator
	output logic [7:0] o_ch0_feedback, // Channel 0 feedback byte
	output logic [7:0] o_ch1_feedback // Channel 1 feedback byte
);
	// ============================================================
	// Control staging and applied image
	logic [7:0] stage [NUM_CH];
	logic [7:0] ctrl [NUM_CH];
	logic [1:0] hw_meta;
	logic [1:0] hw_sync;
	logic [1:0] run_prev;
	logic [1:0] start_pend;
	logic [1:0] fault_b;
	logic [1:0] sel_a;
	logic [1:0] sel_b;
	logic [1:0] sel_fault;
	logic [7:0] next_fb [NUM_CH];

	// Staging bytes written by the bus front end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stage[0] <= CTRL_RESET;
			stage[1] <= CTRL_RESET;
		end else if (i_wr) begin
			if (i_addr == CH0_CTRL_OFFSET) begin
				stage[0] <= i_wdata;
			end else if (i_addr == CH1_CTRL_OFFSET) begin
				stage[1] <= i_wdata;
			end
		end
	end

	// apply at control update
	// Isochronous mode only copies at the cycle instant so both channels switch together
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl[0] <= CTRL_RESET;
			ctrl[1] <= CTRL_RESET;
		end else if (i_isochronous ? i_cycle_start : i_update) begin
			ctrl[0] <= stage[0];
			ctrl[1] <= stage[1];
		end
	end

	// Hardware enable comes from a pin, so synchronise it first
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hw_meta <= 2'h0;
			hw_sync <= 2'h0;
		end else begin
			hw_meta <= i_hw_enable_pin;
			hw_sync <= hw_meta;
		end
	end

	// ============================================================
	// Per-channel sequence control and selection
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			dq_sel_if sif ();
			logic run_en;
			logic edge_ok;
			assign run_en = ctrl[g][BIT_RUN_ENABLE];
			assign edge_ok = run_en & ~run_prev[g] & (~i_hw_enable_use[g] | hw_sync[g]);
			assign sif.source_sel = ctrl[g][BIT_SOURCE_SEL];
			assign sif.level_a = ctrl[g][BIT_LEVEL_A];
			assign sif.level_b = ctrl[g][BIT_LEVEL_B];
			assign sif.dc_motor = i_dc_motor[g];
			assign sif.gen_a = i_gen_a[g];
			assign sif.gen_b = i_gen_b[g];
			assign sif.active = o_seq_run[g];
			assign sel_a[g] = sif.out_a;
			assign sel_b[g] = sif.out_b;
			assign sel_fault[g] = sif.fault_b_req;

			dq_channel_sel u_sel (
				.s(sif)
			);

			// Edge memory of the software enable
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					run_prev[g] <= 1'b0;
				end else begin
					run_prev[g] <= run_en;
				end
			end

			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					start_pend[g] <= 1'b0;
				end else if (!run_en || i_cycle_start) begin
					start_pend[g] <= 1'b0;
				end else if (edge_ok && i_isochronous && !i_hw_enable_use[g]) begin
					start_pend[g] <= 1'b1;
				end
			end

			// start on edge, cancel on zero
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					o_seq_run[g] <= 1'b0;
				end else if (!run_en || i_seq_done[g]) begin
					o_seq_run[g] <= 1'b0;
				end else if (i_isochronous && !i_hw_enable_use[g]) begin
					if (i_cycle_start && (start_pend[g] || edge_ok)) begin
						o_seq_run[g] <= 1'b1;
					end
				end else if (edge_ok) begin
					o_seq_run[g] <= 1'b1;
				end
			end

			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					o_period_sync[g] <= 1'b0;
				end else begin
					o_period_sync[g] <= i_isochronous & i_pwm_mode[g] & i_cycle_start;
				end
			end

			// fault held until acknowledge
			// Set wins over the acknowledge so a fresh fault is never lost
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					fault_b[g] <= 1'b0;
				end else if (sel_fault[g]) begin
					fault_b[g] <= 1'b1;
				end else if (ctrl[g][BIT_ERR_ACK]) begin
					fault_b[g] <= 1'b0;
				end
			end

			// Registered pin drive
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					o_pulse_output_a[g] <= 1'b0;
					o_pulse_output_b[g] <= 1'b0;
				end else begin
					o_pulse_output_a[g] <= sel_a[g];
					o_pulse_output_b[g] <= sel_b[g];
				end
			end

			// Feedback byte contents
			always_comb begin
				next_fb[g] = FB_RESET;
				next_fb[g][FB_BIT_ACTIVE] = o_seq_run[g];
				next_fb[g][FB_BIT_LEVEL_A] = o_pulse_output_a[g];
				next_fb[g][FB_BIT_LEVEL_B] = o_pulse_output_b[g];
				next_fb[g][FB_BIT_FAULT_B] = fault_b[g];
			end
		end
	endgenerate

	// feedback snapshot per cycle
	// Outside isochronous mode the feedback tracks every clock
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ch0_feedback <= FB_RESET;
			o_ch1_feedback <= FB_RESET;
		end else if (!i_isochronous || i_cycle_start) begin
			o_ch0_feedback <= next_fb[0];
			o_ch1_feedback <= next_fb[1];
		end
	end

	// ============================================================
	// Assertions
	a_both_levels_fault: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!i_dc_motor[0] && !ctrl[0][BIT_SOURCE_SEL] && ctrl[0][BIT_LEVEL_A] && ctrl[0][BIT_LEVEL_B])
		|=> (o_pulse_output_a[0] && !o_pulse_output_b[0] && fault_b[0]))
		else $error("both manual levels not resolved");
	a_fault_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(fault_b[0] && !ctrl[0][BIT_ERR_ACK]) |=> fault_b[0])
		else $error("fault cleared without acknowledge");
	a_fault_ack_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(ctrl[0][BIT_ERR_ACK] && !sel_fault[0]) |=> !fault_b[0])
		else $error("fault not cleared by acknowledge");
	a_b_low_module: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!i_dc_motor[0] && ctrl[0][BIT_SOURCE_SEL]) |=> !o_pulse_output_b[0])
		else $error("output b high under module control");
	a_dc_motor_follow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_dc_motor[1] |=> (o_pulse_output_a[1] == $past(i_gen_a[1]) &&
		o_pulse_output_b[1] == $past(i_gen_b[1])))
		else $error("dc motor outputs not from generator");
	a_manual_a_level: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!i_dc_motor[1] && !ctrl[1][BIT_SOURCE_SEL]) |=> o_pulse_output_a[1] == $past(ctrl[1][BIT_LEVEL_A]))
		else $error("manual level a not applied");
	a_cancel_run: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!ctrl[0][BIT_RUN_ENABLE] |=> !o_seq_run[0])
		else $error("sequence runs with enable low");
	a_iso_start_at_cycle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		($rose(o_seq_run[1]) && $past(i_isochronous) && !$past(i_hw_enable_use[1]))
		|-> $past(i_cycle_start))
		else $error("isochronous start off cycle instant");
	a_iso_ctrl_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_isochronous && !i_cycle_start) |=> $stable(ctrl[0]) && $stable(ctrl[1]))
		else $error("control image changed inside cycle");
	a_iso_fb_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_isochronous && !i_cycle_start) |=> $stable(o_ch0_feedback) && $stable(o_ch1_feedback))
		else $error("feedback changed inside cycle");
	c_fault_raised: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(fault_b[0]));
	c_run_start: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(o_seq_run[1]));
	c_background_run: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		o_seq_run[0] && !ctrl[0][BIT_SOURCE_SEL] ##1 ctrl[0][BIT_SOURCE_SEL] && o_seq_run[0]);
endmodule

// ### dq_pkg.sv
// ============================================================
// Package for the per-channel output source selector.
// Assumes a byte-wide control image written by a cyclic bus front end.
package dq_pkg;
	localparam int NUM_CH = 2;
	localparam logic [7:0] CH0_CTRL_OFFSET = 8'h09;
	localparam logic [7:0] CH1_CTRL_OFFSET = 8'h15;
	localparam int BIT_RUN_ENABLE = 0;
	localparam int BIT_SOURCE_SEL = 1;
	localparam int BIT_ERR_ACK = 2;
	localparam int BIT_LEVEL_A = 3;
	localparam int BIT_LEVEL_B = 4;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int FB_BIT_FAULT_B = 5;
	localparam int FB_BIT_LEVEL_A = 1;
	localparam int FB_BIT_LEVEL_B = 2;
	localparam int FB_BIT_ACTIVE = 0;
	localparam logic [7:0] FB_RESET = 8'h00;
endpackage

// ### dq_sel_if.sv
// ============================================================
// Interface carrying one channel's selector inputs and outputs.
// Assumes all signals on the single module clock.
`timescale 1ns/1ps
interface dq_sel_if;
	logic source_sel;
	logic level_a;
	logic level_b;
	logic dc_motor;
	logic gen_a;
	logic gen_b;
	logic active;
	logic out_a;
	logic out_b;
	logic fault_b_req;
	modport top (output source_sel, level_a, level_b, dc_motor, gen_a, gen_b, active,
		input out_a, out_b, fault_b_req);
	modport sel (input source_sel, level_a, level_b, dc_motor, gen_a, gen_b, active,
		output out_a, out_b, fault_b_req);
endinterface

// ### fieldbus_ctrl_model.sv
// ============================================================
// Controller side of the cyclic exchange: writes control bytes, marks updates.
// Assumes one clock shared with the selector; drives only after rising edges.
`timescale 1ns/1ps
module fieldbus_ctrl_model (
	input wire logic i_clk, // Module clock
	output logic o_wr, // Control byte write strobe
	output logic [7:0] o_addr, // Control byte offset
	output logic [7:0] o_wdata, // Control byte data
	output logic o_update, // Control image update pulse
	output logic o_cycle_start // Cycle start instant pulse
);
	// ============================================================
	// Idle levels at time zero
	initial begin
		o_wr = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_update = 1'b0;
		o_cycle_start = 1'b0;
	end

	// whole control byte
	// One byte per write carries select, levels and acknowledge together
	task automatic put_byte(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_wr <= 1'b1;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_addr <= ~a; // Released bus shows junk, not the last value
		o_wdata <= ~d;
	endtask

	// One-cycle update marker; cycle start in isochronous mode
	task automatic apply(input logic iso);
		@(posedge i_clk);
		if (iso) begin
			o_cycle_start <= 1'b1;
		end else begin
			o_update <= 1'b1;
		end
		@(posedge i_clk);
		o_cycle_start <= 1'b0;
		o_update <= 1'b0;
	endtask
endmodule

// ### testbench.sv
// ============================================================
// Self-checking bench for the two-channel output source selector.
// Assumes the controller model; hardware enable driven for one start test.
`timescale 1ns/1ps
module testbench;
	import dq_pkg::*;
	typedef struct packed {
		logic ch;
		logic [7:0] ctrl;
		logic dc;
		logic ga;
		logic gb;
		logic ea;
		logic eb;
	} row_t;
	logic i_clk, i_rst_n, i_wr, i_isochronous, i_cycle_start, i_update;
	logic [7:0] i_addr, i_wdata, o_ch0_feedback, o_ch1_feedback;
	logic [1:0] i_dc_motor, i_pwm_mode, i_gen_a, i_gen_b;
	logic [1:0] o_pulse_output_a, o_pulse_output_b, o_seq_run, o_period_sync;
	logic [1:0] i_hw_enable_pin, i_hw_enable_use;
	logic [7:0] fb_sel;
	logic [1:0] fb_lv;
	int errors = 0;
	int total_checks = 0;
	row_t rows[7] = '{'{1'b0, 8'h00, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0},
		'{1'b0, 8'h08, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0}, '{1'b0, 8'h10, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1},
		'{1'b0, 8'h18, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0}, '{1'b1, 8'h08, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0},
		'{1'b0, 8'h03, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0}, '{1'b0, 8'h19, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1}};

	fieldbus_ctrl_model fieldbus_ctrl_model_inst (.i_clk(i_clk), .o_wr(i_wr), .o_addr(i_addr),
		.o_wdata(i_wdata), .o_update(i_update), .o_cycle_start(i_cycle_start));

	// Sequence end is left idle; the generator never finishes here
	dq_output_direct_control dq_output_direct_control_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata), .i_isochronous(i_isochronous),
		.i_cycle_start(i_cycle_start), .i_update(i_update), .i_hw_enable_pin(i_hw_enable_pin),
		.i_hw_enable_use(i_hw_enable_use), .i_dc_motor(i_dc_motor), .i_pwm_mode(i_pwm_mode),
		.i_gen_a(i_gen_a), .i_gen_b(i_gen_b), .i_seq_done(2'b00),
		.o_pulse_output_a(o_pulse_output_a), .o_pulse_output_b(o_pulse_output_b),
		.o_seq_run(o_seq_run), .o_period_sync(o_period_sync),
		.o_ch0_feedback(o_ch0_feedback), .o_ch1_feedback(o_ch1_feedback));

	// ============================================================
	// Clock and helpers
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Write, apply, then wait past the output and feedback registers
	task automatic wr_apply(input logic [7:0] a, input logic [7:0] d, input logic iso);
		fieldbus_ctrl_model_inst.put_byte(a, d);
		fieldbus_ctrl_model_inst.apply(iso);
		repeat (4) @(negedge i_clk);
	endtask

	task automatic end_sim;
		if (errors == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Whole run needs a few hundred cycles; 2000 is generous
	initial begin
		#40000;
		errors++;
		end_sim();
	end

	// ============================================================
	// Main sequence
	initial begin
		i_rst_n = 1'b0;
		i_isochronous = 1'b0;
		{i_dc_motor, i_pwm_mode, i_gen_a, i_gen_b} = 8'h00;
		{i_hw_enable_pin, i_hw_enable_use} = 4'h0;
		repeat (10) @(posedge i_clk);
		@(negedge i_clk);
		check("rst_out_a", {6'h00, o_pulse_output_a}, 8'h00);
		check("rst_fb0", o_ch0_feedback, FB_RESET);
		@(posedge i_clk);
		i_rst_n <= 1'b1;
		// Table of direct and module control cases, non-isochronous
		for (int i = 0; i < 7; i++) begin
			@(posedge i_clk);
			i_dc_motor <= {2{rows[i].dc}};
			i_gen_a <= {2{rows[i].ga}};
			i_gen_b <= {2{rows[i].gb}};
			wr_apply(rows[i].ch ? CH1_CTRL_OFFSET : CH0_CTRL_OFFSET, rows[i].ctrl, 1'b0);
			check("out_a", {7'h00, o_pulse_output_a[rows[i].ch]}, {7'h00, rows[i].ea});
			check("out_b", {7'h00, o_pulse_output_b[rows[i].ch]}, {7'h00, rows[i].eb});
			// Feedback level bits follow the pins one clock later
			fb_sel = rows[i].ch ? o_ch1_feedback : o_ch0_feedback;
			fb_lv = {fb_sel[FB_BIT_LEVEL_B], fb_sel[FB_BIT_LEVEL_A]};
			check("fb_levels", {6'h00, fb_lv}, {6'h00, rows[i].eb, rows[i].ea});
		end
		@(posedge i_clk);
		i_dc_motor <= 2'b00;
		i_gen_b <= 2'b00;
		i_gen_a <= 2'b11;
		// Sticky fault until acknowledge; clear the one left by the table first
		wr_apply(CH0_CTRL_OFFSET, 8'h04, 1'b0);
		wr_apply(CH0_CTRL_OFFSET, 8'h18, 1'b0);
		check("fault_set", {7'h00, o_ch0_feedback[FB_BIT_FAULT_B]}, 8'h01);
		wr_apply(CH0_CTRL_OFFSET, 8'h08, 1'b0);
		check("fault_hold", {7'h00, o_ch0_feedback[FB_BIT_FAULT_B]}, 8'h01);
		wr_apply(CH0_CTRL_OFFSET, 8'h0c, 1'b0);
		check("fault_clr", {7'h00, o_ch0_feedback[FB_BIT_FAULT_B]}, 8'h00);
		// Background sequence across a direct control episode
		wr_apply(CH0_CTRL_OFFSET, 8'h03, 1'b0);
		check("run_on", {7'h00, o_seq_run[0]}, 8'h01);
		wr_apply(CH0_CTRL_OFFSET, 8'h01, 1'b0);
		check("bg_run", {6'h00, o_seq_run[0], o_pulse_output_a[0]}, 8'h02);
		wr_apply(CH0_CTRL_OFFSET, 8'h03, 1'b0);
		check("regain", {7'h00, o_pulse_output_a[0]}, 8'h01);
		wr_apply(CH0_CTRL_OFFSET, 8'h02, 1'b0);
		check("cancel", {6'h00, o_seq_run[0], o_pulse_output_a[0]}, 8'h00);
		// Hardware enable qualification: low pin blocks the edge, high pin lets it start
		@(posedge i_clk);
		i_hw_enable_use <= 2'b01;
		wr_apply(CH0_CTRL_OFFSET, 8'h03, 1'b0);
		check("hw_block", {7'h00, o_seq_run[0]}, 8'h00);
		@(posedge i_clk);
		i_hw_enable_pin <= 2'b01;
		wr_apply(CH0_CTRL_OFFSET, 8'h02, 1'b0);
		wr_apply(CH0_CTRL_OFFSET, 8'h03, 1'b0);
		check("hw_start", {7'h00, o_seq_run[0]}, 8'h01);
		wr_apply(CH0_CTRL_OFFSET, 8'h02, 1'b0);
		@(posedge i_clk);
		i_hw_enable_use <= 2'b00;
		wr_apply(8'h0a, 8'h08, 1'b0);
		check("unmapped", {6'h00, o_pulse_output_a}, 8'h02);
		// Isochronous: staged bytes wait for the cycle start instant
		@(posedge i_clk);
		i_isochronous <= 1'b1;
		i_pwm_mode <= 2'b11;
		fieldbus_ctrl_model_inst.put_byte(CH0_CTRL_OFFSET, 8'h01);
		wr_apply(CH1_CTRL_OFFSET, 8'h01, 1'b0);
		check("iso_wait", {6'h00, o_seq_run}, 8'h00);
		fieldbus_ctrl_model_inst.apply(1'b1);
		@(negedge i_clk);
		check("period_sync", {6'h00, o_period_sync}, 8'h03);
		// The enable edge is seen after take-over, so the run waits for the next instant
		fieldbus_ctrl_model_inst.apply(1'b1);
		repeat (2) @(negedge i_clk);
		check("iso_run", {6'h00, o_seq_run}, 8'h03);
		check("fb_old", {7'h00, o_ch0_feedback[FB_BIT_ACTIVE]}, 8'h00);
		wr_apply(8'h0a, 8'h00, 1'b1);
		check("fb_snap", {6'h00, o_ch1_feedback[FB_BIT_ACTIVE], o_ch0_feedback[FB_BIT_ACTIVE]}, 8'h03);
		// Mid-run reset, then a first write straight after release
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		@(negedge i_clk);
		check("rst_run", {6'h00, o_seq_run}, 8'h00);
		check("rst_fb1", o_ch1_feedback, FB_RESET);
		@(posedge i_clk);
		i_rst_n <= 1'b1;
		wr_apply(CH1_CTRL_OFFSET, 8'h08, 1'b1);
		check("rst_iso_a", {6'h00, o_pulse_output_a}, 8'h02);
		end_sim();
	end
endmodule
